/* File: ddaf_former.sv */
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// How it works
// - direct address is page pointer then offset
// - 512 pages of 128 words each
// - opcode bits 15:8, bit7 zero is direct
// - bit7 one takes the indirect path
// - page pointer loads only by two instructions
// - page pointer not initialised by reset
// - indirect address from one of eight registers
// - short immediate of 8, 9 or 13 bits
// - long immediate is the following word
// - block move and logic unit registers
// - circular mode wraps to block start
// - shifted add count from bits 11:8
module ddaf_former (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // instruction from decode
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [15:0] next_word_i,
  input wire logic long_imm_i,
  input wire logic short_imm_i,
  input wire ddaf_pkg::ddaf_imm_t imm_size_i,
  input wire logic block_move_i,
  input wire logic plu_op_i,
  // page pointer load
  input wire ddaf_pkg::ddaf_pp_t pp_load_i,
  input wire logic [8:0] pp_data_i,
  // auxiliary registers
  input wire logic ar_we_i,
  input wire logic [2:0] ar_wsel_i,
  input wire logic [15:0] ar_wdata_i,
  input wire logic [2:0] aux_reg_pointer_i,
  input wire logic circ_en_i,
  input wire logic [15:0] circ_start_i,
  input wire logic [15:0] circ_end_i,
  // dedicated registers
  input wire logic [15:0] block_move_addr_reg_i,
  input wire logic [15:0] bit_manip_operand_reg_i,
  // outputs
  output logic [15:0] dmem_addr_o,
  output logic addr_valid_o,
  output logic [15:0] operand_o,
  output logic operand_valid_o,
  output ddaf_pkg::ddaf_src_t src_o,
  output logic [7:0] opcode_o,
  output logic [3:0] shift_o,
  output logic [8:0] page_pointer_o
);
  logic [8:0] page_pointer;
  logic [15:0] imm;
  logic [15:0] next_addr;
  logic [15:0] next_operand;
  logic next_addr_valid;
  logic next_operand_valid;
  ddaf_pkg::ddaf_src_t next_src;
  logic is_indirect;
  ddaf_aux_if aux ();

  assign is_indirect = instr_i[ddaf_pkg::MODE_BIT];
  assign aux.sel = aux_reg_pointer_i;
  assign aux.wrap_en = circ_en_i;
  assign aux.blk_start = circ_start_i;
  assign aux.blk_end = circ_end_i;

  ddaf_aux_bank u_bank (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ar_we_i(ar_we_i),
    .ar_wsel_i(ar_wsel_i),
    .ar_wdata_i(ar_wdata_i),
    .aux(aux.bank)
  );

  ddaf_imm_ext u_imm (
    .instr_i(instr_i),
    .size_i(imm_size_i),
    .imm_o(imm)
  );

  // page pointer keeps its value unless loaded; no reset term
  always_ff @(posedge clock_i) begin
    unique case (pp_load_i)
      ddaf_pkg::DDAF_PP_LOAD_PAGE: page_pointer <= pp_data_i;
      ddaf_pkg::DDAF_PP_LOAD_STATUS: page_pointer <= pp_data_i;
      default: page_pointer <= page_pointer;
    endcase
  end

  // source selection
  always_comb begin
    next_addr = 16'h0000;
    next_operand = 16'h0000;
    next_addr_valid = 1'b0;
    next_operand_valid = 1'b0;
    next_src = ddaf_pkg::DDAF_SRC_DIRECT;
    if (instr_valid_i) begin
      if (long_imm_i) begin
        next_src = ddaf_pkg::DDAF_SRC_LONG_IMM;
        next_operand = next_word_i;
        next_operand_valid = 1'b1;
      end else if (short_imm_i) begin
        next_src = ddaf_pkg::DDAF_SRC_SHORT_IMM;
        next_operand = imm;
        next_operand_valid = 1'b1;
      end else if (block_move_i) begin
        next_src = ddaf_pkg::DDAF_SRC_BLOCK_MOVE;
        next_addr = block_move_addr_reg_i;
        next_addr_valid = 1'b1;
      end else if (plu_op_i) begin
        next_src = ddaf_pkg::DDAF_SRC_PLU;
        next_operand = bit_manip_operand_reg_i;
        next_operand_valid = 1'b1;
        next_addr = is_indirect ? aux.eff_addr :
          {page_pointer, instr_i[6:0]};
        next_addr_valid = 1'b1;
      end else if (is_indirect) begin
        next_src = ddaf_pkg::DDAF_SRC_INDIRECT;
        next_addr = aux.eff_addr;
        next_addr_valid = 1'b1;
      end else begin
        next_src = ddaf_pkg::DDAF_SRC_DIRECT;
        next_addr = {page_pointer, instr_i[6:0]};
        next_addr_valid = 1'b1;
      end
    end
  end

  // registered outputs, one cycle after the instruction
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dmem_addr_o <= 16'h0000;
      addr_valid_o <= 1'b0;
      operand_o <= 16'h0000;
      operand_valid_o <= 1'b0;
      src_o <= ddaf_pkg::DDAF_SRC_DIRECT;
    end else begin
      dmem_addr_o <= next_addr;
      addr_valid_o <= next_addr_valid;
      operand_o <= next_operand;
      operand_valid_o <= next_operand_valid;
      src_o <= next_src;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      opcode_o <= 8'h00;
      shift_o <= 4'h0;
    end else if (instr_valid_i) begin
      opcode_o <= instr_i[15:8];
      shift_o <= instr_i[11:8];
    end
  end

  assign page_pointer_o = page_pointer;

  // decode classes re-derived for the checks below
  logic mem_op;
  logic direct_op;
  logic indirect_op;
  logic short_op;
  logic plu_only;
  assign mem_op = instr_valid_i && !long_imm_i && !short_imm_i &&
    !block_move_i && !plu_op_i;
  assign direct_op = mem_op && !instr_i[ddaf_pkg::MODE_BIT];
  assign indirect_op = mem_op && instr_i[ddaf_pkg::MODE_BIT];
  assign short_op = instr_valid_i && short_imm_i && !long_imm_i;
  assign plu_only = instr_valid_i && plu_op_i && !long_imm_i &&
    !short_imm_i && !block_move_i;

  // set by the first pointer load; unknown pointer is not checked before
  logic pp_loaded;
  always_ff @(posedge clock_i) begin
    if (pp_load_i != ddaf_pkg::DDAF_PP_NONE) begin
      pp_loaded <= 1'b1;
    end
  end

  direct_addr_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    direct_op |=> addr_valid_o &&
    dmem_addr_o == {$past(page_pointer), $past(instr_i[6:0])})
    else $error("direct address wrong");

  page_offset_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    addr_valid_o && src_o == ddaf_pkg::DDAF_SRC_DIRECT |->
    dmem_addr_o[15:7] == $past(page_pointer))
    else $error("page field wrong");

  page_word_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    direct_op |=> dmem_addr_o[6:0] == $past(instr_i[6:0]))
    else $error("in-page word wrong");

  opcode_field_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    instr_valid_i |=> opcode_o == $past(instr_i[15:8]))
    else $error("opcode wrong");

  direct_src_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    direct_op |=> src_o == ddaf_pkg::DDAF_SRC_DIRECT &&
    !operand_valid_o)
    else $error("direct mode not selected");

  field_hold_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !instr_valid_i |=> $stable(opcode_o) && $stable(shift_o))
    else $error("opcode fields changed while idle");

  indirect_path_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    indirect_op |=> addr_valid_o && src_o == ddaf_pkg::DDAF_SRC_INDIRECT &&
    dmem_addr_o == $past(aux.eff_addr))
    else $error("indirect path wrong");

  mode_bit_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    mem_op |=> (src_o == ddaf_pkg::DDAF_SRC_INDIRECT) == $past(instr_i[7]))
    else $error("mode bit decode wrong");

  indirect_reg_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    indirect_op && !circ_en_i |=> dmem_addr_o == $past(aux.addr))
    else $error("auxiliary register address wrong");

  aux_write_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    ar_we_i && ar_wsel_i == aux_reg_pointer_i |=>
    aux_reg_pointer_i != $past(aux_reg_pointer_i) ||
    aux.addr == $past(ar_wdata_i))
    else $error("auxiliary register not written");

  circ_wrap_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    indirect_op && circ_en_i && aux.addr > circ_end_i |=>
    dmem_addr_o == $past(circ_start_i))
    else $error("circular wrap missing");

  circ_inside_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    indirect_op && circ_en_i && aux.addr <= circ_end_i |=>
    dmem_addr_o == $past(aux.addr))
    else $error("address wrapped inside block");

  page_hold_a: assert property (
    @(posedge clock_i)
    pp_loaded && pp_load_i == ddaf_pkg::DDAF_PP_NONE |=>
    $stable(page_pointer))
    else $error("page pointer changed");

  page_load_a: assert property (
    @(posedge clock_i)
    pp_load_i != ddaf_pkg::DDAF_PP_NONE |=>
    page_pointer == $past(pp_data_i))
    else $error("page pointer not loaded");

  page_reset_a: assert property (
    @(posedge clock_i)
    reset_i && pp_loaded && pp_load_i == ddaf_pkg::DDAF_PP_NONE |=>
    $stable(page_pointer))
    else $error("reset disturbed page pointer");

  long_imm_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    instr_valid_i && long_imm_i |=> operand_valid_o &&
    operand_o == $past(next_word_i))
    else $error("long immediate wrong");

  long_src_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    instr_valid_i && long_imm_i |=> !addr_valid_o &&
    src_o == ddaf_pkg::DDAF_SRC_LONG_IMM)
    else $error("long immediate source wrong");

  short_imm8_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    short_op && imm_size_i == ddaf_pkg::DDAF_IMM8 |=>
    operand_o == {8'h00, $past(instr_i[7:0])})
    else $error("8-bit immediate wrong");

  short_imm9_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    short_op && imm_size_i == ddaf_pkg::DDAF_IMM9 |=>
    operand_o == {7'h00, $past(instr_i[8:0])})
    else $error("9-bit immediate wrong");

  short_imm13_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    short_op && imm_size_i == ddaf_pkg::DDAF_IMM13 |=>
    operand_o == {3'h0, $past(instr_i[12:0])})
    else $error("13-bit immediate wrong");

  short_src_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    short_op |=> operand_valid_o && !addr_valid_o &&
    src_o == ddaf_pkg::DDAF_SRC_SHORT_IMM)
    else $error("short immediate source wrong");

  shift_cnt_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    instr_valid_i |=> shift_o == $past(instr_i[11:8]))
    else $error("shift count wrong");

  block_move_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    instr_valid_i && block_move_i && !long_imm_i && !short_imm_i |=>
    dmem_addr_o == $past(block_move_addr_reg_i))
    else $error("block move address wrong");

  block_src_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    instr_valid_i && block_move_i && !long_imm_i && !short_imm_i |=>
    addr_valid_o && src_o == ddaf_pkg::DDAF_SRC_BLOCK_MOVE)
    else $error("block move source wrong");

  plu_operand_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    plu_only |=> operand_valid_o && src_o == ddaf_pkg::DDAF_SRC_PLU &&
    operand_o == $past(bit_manip_operand_reg_i))
    else $error("logic unit operand wrong");

  plu_addr_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    plu_only && !instr_i[7] |=> addr_valid_o &&
    dmem_addr_o == {$past(page_pointer), $past(instr_i[6:0])})
    else $error("logic unit address wrong");

  both_valid_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    addr_valid_o && operand_valid_o |-> src_o == ddaf_pkg::DDAF_SRC_PLU)
    else $error("two results outside logic unit");

  idle_out_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !instr_valid_i |=> !addr_valid_o && !operand_valid_o)
    else $error("valid without instruction");

  reset_out_a: assert property (
    @(posedge clock_i)
    reset_i |=> !addr_valid_o && !operand_valid_o &&
    dmem_addr_o == 16'h0000)
    else $error("outputs not cleared by reset");
endmodule

/* File: ddaf_pkg.sv */
package ddaf_pkg;
  localparam int ADDR_W = 16;
  localparam int PAGE_W = 9;
  localparam int OFS_W = 7;
  localparam int NUM_PAGES = 512;
  localparam int PAGE_WORDS = 128;
  localparam int MODE_BIT = 7;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int SHIFT_HI = 11;
  localparam int SHIFT_LO = 8;
  localparam int ARP_W = 3;
  localparam int NUM_AR = 8;
  localparam int TC_PAGE_ST0 = 7;
  localparam logic [15:0] PAGE_POINTER_SIM = 16'h0000;
  typedef enum logic [2:0] {
    DDAF_SRC_DIRECT,
    DDAF_SRC_INDIRECT,
    DDAF_SRC_SHORT_IMM,
    DDAF_SRC_LONG_IMM,
    DDAF_SRC_BLOCK_MOVE,
    DDAF_SRC_PLU
  } ddaf_src_t;
  typedef enum logic [1:0] {
    DDAF_IMM8,
    DDAF_IMM9,
    DDAF_IMM13
  } ddaf_imm_t;
  typedef enum logic [1:0] {
    DDAF_PP_NONE,
    DDAF_PP_LOAD_PAGE,
    DDAF_PP_LOAD_STATUS
  } ddaf_pp_t;
endpackage

/* File: ddaf_aux_if.sv */
`timescale 1ns/1ns
interface ddaf_aux_if;
  logic [2:0] sel;
  logic [15:0] addr;
  logic wrap_en;
  logic [15:0] blk_start;
  logic [15:0] blk_end;
  logic [15:0] eff_addr;
  modport src (output sel, output wrap_en, output blk_start,
    output blk_end, input eff_addr, input addr);
  modport bank (input sel, input wrap_en, input blk_start,
    input blk_end, output eff_addr, output addr);
endinterface

/* File: ddaf_aux_bank.sv */
`timescale 1ns/1ns
module ddaf_aux_bank (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // register load
  input wire logic ar_we_i,
  input wire logic [2:0] ar_wsel_i,
  input wire logic [15:0] ar_wdata_i,
  // address side
  ddaf_aux_if.bank aux
);
  logic [15:0] ar [ddaf_pkg::NUM_AR];
  genvar g;
  generate
    for (g = 0; g < ddaf_pkg::NUM_AR; g++) begin : g_ar
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          ar[g] <= 16'h0000;
        end else if (ar_we_i && ar_wsel_i == 3'(g)) begin
          ar[g] <= ar_wdata_i;
        end
      end
    end
  endgenerate
  // selected register and circular wrap
  assign aux.addr = ar[aux.sel];
  assign aux.eff_addr = (aux.wrap_en && aux.addr > aux.blk_end) ?
    aux.blk_start : aux.addr;
endmodule

/* File: ddaf_imm_ext.sv */
`timescale 1ns/1ns
module ddaf_imm_ext (
  // instruction and size
  input wire logic [15:0] instr_i,
  input wire ddaf_pkg::ddaf_imm_t size_i,
  // operand
  output logic [15:0] imm_o
);
  always_comb begin
    unique case (size_i)
      ddaf_pkg::DDAF_IMM8: imm_o = {8'h00, instr_i[7:0]};
      ddaf_pkg::DDAF_IMM9: imm_o = {7'h00, instr_i[8:0]};
      ddaf_pkg::DDAF_IMM13: imm_o = {3'h0, instr_i[12:0]};
      default: imm_o = 16'h0000;
    endcase
  end
endmodule

/* File: ddaf_dmem_model.sv */
`timescale 1ns/1ns
module ddaf_dmem_model (
  // clock
  input wire logic clock_i,
  // access from the former
  input wire logic [15:0] addr_i,
  input wire logic valid_i,
  // last address taken
  output logic [15:0] last_addr_o
);
  // memory takes the address in the cycle it stands, no wait
  always @(posedge clock_i) begin
    if (valid_i === 1'b1) begin
      last_addr_o <= addr_i;
    end
  end
endmodule

/* File: direct_data_address_former_tb_top.sv */
`timescale 1ns/1ns
module direct_data_address_former_tb_top;
  logic clock_i = 1'b0, reset_i = 1'b1, instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000, next_word_i = 16'h0000;
  logic long_imm_i = 1'b0, short_imm_i = 1'b0;
  logic block_move_i = 1'b0, plu_op_i = 1'b0;
  ddaf_pkg::ddaf_imm_t imm_size_i = ddaf_pkg::DDAF_IMM8;
  ddaf_pkg::ddaf_pp_t pp_load_i = ddaf_pkg::DDAF_PP_NONE;
  logic [8:0] pp_data_i = 9'h000;
  logic ar_we_i = 1'b0, circ_en_i = 1'b0;
  logic [2:0] ar_wsel_i = 3'h0, aux_reg_pointer_i = 3'h0;
  logic [15:0] ar_wdata_i = 16'h0000, circ_start_i = 16'h0000;
  logic [15:0] circ_end_i = 16'hffff, block_move_addr_reg_i = 16'h0000;
  logic [15:0] bit_manip_operand_reg_i = 16'h0000;
  logic [15:0] dmem_addr_o, operand_o, last_addr;
  logic addr_valid_o, operand_valid_o;
  ddaf_pkg::ddaf_src_t src_o;
  logic [7:0] opcode_o;
  logic [3:0] shift_o;
  logic [8:0] page_pointer_o;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  ddaf_former u_dut (.clock_i, .reset_i, .instr_valid_i, .instr_i,
    .next_word_i, .long_imm_i, .short_imm_i, .imm_size_i, .block_move_i,
    .plu_op_i, .pp_load_i, .pp_data_i, .ar_we_i, .ar_wsel_i, .ar_wdata_i,
    .aux_reg_pointer_i, .circ_en_i, .circ_start_i, .circ_end_i,
    .block_move_addr_reg_i, .bit_manip_operand_reg_i, .dmem_addr_o,
    .addr_valid_o, .operand_o, .operand_valid_o, .src_o, .opcode_o,
    .shift_o, .page_pointer_o);
  ddaf_dmem_model u_mem (.clock_i(clock_i), .addr_i(dmem_addr_o),
    .valid_i(addr_valid_o), .last_addr_o(last_addr));

  always #20 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one instruction with its class flags {long, short, block, logic unit}
  task automatic issue(input logic [15:0] ins, input logic [3:0] cls);
    @(posedge clock_i);
    instr_i <= ins;
    instr_valid_i <= 1'b1;
    {long_imm_i, short_imm_i, block_move_i, plu_op_i} <= cls;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    {long_imm_i, short_imm_i, block_move_i, plu_op_i} <= 4'h0;
    @(negedge clock_i);
  endtask

  task automatic load_pp(input ddaf_pkg::ddaf_pp_t k, input logic [8:0] v);
    @(posedge clock_i);
    pp_load_i <= k;
    pp_data_i <= v;
    @(posedge clock_i);
    pp_load_i <= ddaf_pkg::DDAF_PP_NONE;
  endtask

  task automatic t_direct;
    load_pp(ddaf_pkg::DDAF_PP_LOAD_PAGE, 9'h003);
    issue(16'h2509, 4'h0);
    chk("addr", 16'h0189, dmem_addr_o);
    chk("valid", 16'h0001, {15'h0, addr_valid_o});
    chk("src", 16'h0000, {13'h0, src_o});
    chk("opcode", 16'h0025, {8'h00, opcode_o});
    chk("shift", 16'h0005, {12'h000, shift_o});
    @(negedge clock_i);
    chk("valid", 16'h0000, {15'h0, addr_valid_o});
    chk("mem", 16'h0189, last_addr);
    load_pp(ddaf_pkg::DDAF_PP_LOAD_STATUS, 9'h1ff);
    issue(16'hff7f, 4'h0);
    chk("addr", 16'hffff, dmem_addr_o);
    load_pp(ddaf_pkg::DDAF_PP_NONE, 9'h000);
    issue(16'h1000, 4'h0);
    chk("addr", 16'hff80, dmem_addr_o);
    chk("page", 16'h01ff, {7'h00, page_pointer_o});
  endtask

  task automatic t_indirect;
    for (int k = 0; k < 8; k++) begin
      @(posedge clock_i);
      ar_we_i <= 1'b1;
      ar_wsel_i <= 3'(k);
      ar_wdata_i <= 16'h1000 + 16'(k) * 16'h0111;
    end
    @(posedge clock_i);
    ar_we_i <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(posedge clock_i);
      aux_reg_pointer_i <= 3'(k);
      issue(16'h2080, 4'h0);
      chk("ind", 16'h1000 + 16'(k) * 16'h0111, dmem_addr_o);
      chk("src", 16'h0001, {13'h0, src_o});
    end
    @(posedge clock_i);
    circ_en_i <= 1'b1;
    circ_start_i <= 16'h0200;
    circ_end_i <= 16'h1300;
    issue(16'h2080, 4'h0);
    chk("wrap", 16'h0200, dmem_addr_o);
    @(posedge clock_i);
    aux_reg_pointer_i <= 3'h1;
    issue(16'h2080, 4'h0);
    chk("nowrap", 16'h1111, dmem_addr_o);
  endtask

  task automatic t_operand;
    ddaf_pkg::ddaf_imm_t sz[3];
    logic [15:0] msk[3];
    sz = '{ddaf_pkg::DDAF_IMM8, ddaf_pkg::DDAF_IMM9, ddaf_pkg::DDAF_IMM13};
    msk = '{16'h00ff, 16'h01ff, 16'h1fff};
    for (int k = 0; k < 3; k++) begin
      @(posedge clock_i);
      imm_size_i <= sz[k];
      issue(16'hffff, 4'h4);
      chk("short", msk[k], operand_o);
      chk("opvalid", 16'h0001, {15'h0, operand_valid_o});
    end
    @(posedge clock_i);
    next_word_i <= 16'ha5c3;
    block_move_addr_reg_i <= 16'h4321;
    bit_manip_operand_reg_i <= 16'h8765;
    issue(16'hbf00, 4'hc);
    chk("long", 16'ha5c3, operand_o);
    chk("src", 16'h0003, {13'h0, src_o});
    issue(16'h0000, 4'h2);
    chk("block", 16'h4321, dmem_addr_o);
    issue(16'h0000, 4'h1);
    chk("logic", 16'h8765, operand_o);
    chk("src", 16'h0005, {13'h0, src_o});
  endtask

  task automatic t_reset;
    load_pp(ddaf_pkg::DDAF_PP_LOAD_PAGE, 9'h0a5);
    issue(16'h2a11, 4'h0);
    chk("addr", 16'h5291, dmem_addr_o);
    @(posedge clock_i);
    reset_i <= 1'b1;
    @(posedge clock_i);
    @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    chk("rst valid", 16'h0000, {15'h0, addr_valid_o});
    chk("rst opvalid", 16'h0000, {15'h0, operand_valid_o});
    chk("rst opcode", 16'h0000, {8'h00, opcode_o});
    chk("rst page", 16'h00a5, {7'h00, page_pointer_o});
    issue(16'h2a11, 4'h0);
    chk("addr", 16'h5291, dmem_addr_o);
    chk("opcode", 16'h002a, {8'h00, opcode_o});
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    t_direct();
    t_indirect();
    t_operand();
    t_reset();
    final_report();
  end
endmodule
